//--- core/cvi_top.sv
// Clocked video input packetizer with its output FIFO
`timescale 1ns/1ns
`default_nettype none
`include "cvi_defs.svh"

// ----------------------------------------------------------------
// Output FIFO
// ----------------------------------------------------------------
// Shift-register FIFO: the head always sits in entry 0, so the data
// and valid seen by the drain come straight from flip-flops.
module cvi_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Fill side
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // Drain side
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  logic [WIDTH-1:0] mem_q [DEPTH], mem_d [DEPTH], sdat [DEPTH];
  logic [DEPTH-1:0] vld_q, vld_d, sv;
  logic pop, push;

  // Ready only from the tail flag; no pass-through when full
  assign in_ready_o = ~vld_q[DEPTH-1];
  assign out_valid_o = vld_q[0];
  assign out_data_o = mem_q[0];
  assign pop = vld_q[0] & out_ready_i;
  assign push = in_valid_i & ~vld_q[DEPTH-1];

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    if (i == DEPTH - 1) begin : g_tail
      assign sv[i] = pop ? 1'b0 : vld_q[i];
      assign sdat[i] = mem_q[i];
    end else begin : g_body
      assign sv[i] = pop ? vld_q[i+1] : vld_q[i];
      assign sdat[i] = pop ? mem_q[i+1] : mem_q[i];
    end
    if (i == 0) begin : g_head
      always_comb begin
        vld_d[i] = sv[i] | push;
        mem_d[i] = (push & ~sv[i]) ? in_data_i : sdat[i];
      end
    end else begin : g_rest
      always_comb begin
        vld_d[i] = sv[i] | (push & ~sv[i] & sv[i-1]);
        mem_d[i] = (push & ~sv[i] & sv[i-1]) ? in_data_i : sdat[i];
      end
    end
    always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
        {vld_q[i], mem_q[i]} <= '0;
      end else begin
        {vld_q[i], mem_q[i]} <= {vld_d[i], mem_d[i]};
      end
    end
  end
endmodule

// Behaviour
// R01: Blanking is dropped and only active samples go out, framed by control and video packets.
// R02: Samples arrive as chroma then luma in one sequence, with both chroma parts as one plane.
// R03: Measured resolution is published only once a whole frame has been seen.
// R04: Until a frame is measured, control packets carry interlaced, 720 wide, 244 and 243 lines.
// R05: Input timing is embedded in the samples and output is a valid and ready stream.
// R06: The video clock domain is sampled and its data crosses to the system clock safely.
// R07: No field is accepted unless the enable input from the processor is high at its start.
// R08: Measured width, field heights and interlace flag are held on status outputs.
// R09: A one-cycle status change pulse marks each update of the published format.
// R10: The source marks each valid sample and asserts lock only while its timing is stable.
module cvi_top (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Clocked video from the decoder
  input wire logic vid_clk_i,
  input wire logic [7:0] vid_data_i,
  input wire logic vid_datavalid_i,
  input wire logic vid_locked_i,
  // Control
  input wire logic enable_i,
  // Stream out
  output logic [7:0] dout_data_o,
  output logic dout_sop_o,
  output logic dout_eop_o,
  output logic dout_valid_o,
  input wire logic dout_ready_i,
  // Status
  output logic [15:0] width_o,
  output logic [15:0] height0_o,
  output logic [15:0] height1_o,
  output logic interlaced_o,
  output logic status_valid_o,
  output logic status_change_o,
  output logic overflow_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Data takes a third stage so the word used at a clock edge is the
  // one settled half a sample before, clear of its launch edge.
  logic [2:0] clk_s;
  logic [7:0] dat_s1, dat_s2, dat_s3;
  logic [2:0] dv_s;
  logic [1:0] lock_s;
  logic tick;
  logic [7:0] smp;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      // History resets high so a pin already high gives no false rise
      clk_s <= '1;
      {dat_s1, dat_s2, dat_s3, dv_s, lock_s} <= '0;
    end else begin
      clk_s <= {clk_s[1:0], vid_clk_i};
      {dat_s3, dat_s2, dat_s1} <= {dat_s2, dat_s1, vid_data_i};
      {dv_s, lock_s} <= {dv_s[1:0], vid_datavalid_i, lock_s[0], vid_locked_i};
    end
  end

  assign tick = clk_s[1] & ~clk_s[2] & dv_s[2]; // R06 R10
  assign smp = dat_s3;

  // ----------------------------------------------------------------
  // Parser, measurement and packet generation
  // ----------------------------------------------------------------
  cvi_pkg::trs_state_t trs_q, trs_d;
  cvi_pkg::pkt_word_t fin_data, gen_word, fout_data;
  logic fin_valid, fin_ready, fout_valid;
  logic act_q, act_d, vprev_q, vprev_d, field_q, field_d, accept_q, accept_d;
  logic seen0_q, seen0_d, gen_q, gen_d, hold_v_q, hold_v_d, live_q, live_d;
  logic [3:0] gen_idx_q, gen_idx_d;
  logic [7:0] hold_q, hold_d;
  logic [11:0] samp_q, samp_d;
  logic [10:0] lines_q, lines_d, lcount;
  logic [15:0] mw_q, mw_d, mh0_q, mh0_d;
  logic [15:0] sw_q, sw_d, sh0_q, sh0_d, sh1_q, sh1_d;
  logic si_q, si_d, sval_q, sval_d, chg_q, chg_d, ovf_q, ovf_d;
  logic [15:0] cw, ch;
  logic ci;
  logic fv, vv, hv;

  always_comb begin
    trs_d = trs_q;
    {act_d, vprev_d, field_d, accept_d} = {act_q, vprev_q, field_q, accept_q};
    {seen0_d, gen_d, hold_v_d, live_d} = {seen0_q, gen_q, hold_v_q, live_q};
    {gen_idx_d, hold_d, samp_d, lines_d} = {gen_idx_q, hold_q, samp_q, lines_q};
    {mw_d, mh0_d, sw_d, sh0_d, sh1_d} = {mw_q, mh0_q, sw_q, sh0_q, sh1_q};
    {si_d, sval_d, chg_d, ovf_d} = {si_q, sval_q, 2'b00};
    fin_valid = 1'b0;
    fin_data = '0;
    fv = smp[`CVI_BIT_F];
    vv = smp[`CVI_BIT_V];
    hv = smp[`CVI_BIT_H];
    lcount = lines_q + {10'h000, act_q};
    // Defaults stand in until a full frame is measured
    cw = sval_q ? sw_q : `CVI_DEF_WIDTH; // R04
    ci = sval_q ? si_q : `CVI_DEF_INTL; // R04
    ch = (ci & field_q) ? (sval_q ? sh1_q : `CVI_DEF_H1) : (sval_q ? sh0_q : `CVI_DEF_H0); // R04

    // Control packet nibbles, then the video packet header word
    gen_word = '0;
    unique case (gen_idx_q)
      4'h0: gen_word.data = {4'h0, `CVI_TYPE_CTRL};
      4'h1: gen_word.data = {4'h0, cw[15:12]};
      4'h2: gen_word.data = {4'h0, cw[11:8]};
      4'h3: gen_word.data = {4'h0, cw[7:4]};
      4'h4: gen_word.data = {4'h0, cw[3:0]};
      4'h5: gen_word.data = {4'h0, ch[15:12]};
      4'h6: gen_word.data = {4'h0, ch[11:8]};
      4'h7: gen_word.data = {4'h0, ch[7:4]};
      4'h8: gen_word.data = {4'h0, ch[3:0]};
      4'h9: gen_word.data = {4'h0, ci, field_q, 2'b00};
      4'hA: gen_word.data = {4'h0, `CVI_TYPE_VIDEO};
      default: gen_word.data = 8'h00;
    endcase
    gen_word.sop = (gen_idx_q == 4'h0) | (gen_idx_q == `CVI_GEN_LAST);
    gen_word.eop = (gen_idx_q == `CVI_GEN_EOP);

    if (gen_q) begin
      fin_valid = 1'b1;
      fin_data = gen_word;
      if (fin_ready) begin
        gen_idx_d = (gen_idx_q == `CVI_GEN_LAST) ? 4'h0 : gen_idx_q + 4'h1;
        gen_d = (gen_idx_q != `CVI_GEN_LAST);
      end
    end

    if (!lock_s[1]) begin
      // Timing unstable: abandon the field, its packet may stay short
      trs_d = cvi_pkg::TRS_IDLE; // R10
      {act_d, accept_d, hold_v_d, vprev_d, seen0_d, live_d} = '0;
    end else if (tick) begin
      unique case (trs_q)
        cvi_pkg::TRS_IDLE: begin
          if (smp == `CVI_TRS_MARK) begin
            trs_d = cvi_pkg::TRS_MARK;
          end else if (act_q) begin
            samp_d = samp_q + 12'h001;
            if (accept_q) begin
              // One sample is held back so the last one can carry eop
              if (hold_v_q) begin
                if (gen_q | ~fin_ready) begin
                  ovf_d = 1'b1;
                end else begin
                  fin_valid = 1'b1;
                  fin_data = '{sop: 1'b0, eop: 1'b0, data: hold_q}; // R01 R02
                end
              end
              hold_d = smp;
              hold_v_d = 1'b1;
            end
          end
        end
        cvi_pkg::TRS_MARK: begin
          trs_d = (smp == `CVI_TRS_ZERO) ? cvi_pkg::TRS_Z1 : cvi_pkg::TRS_IDLE;
        end
        cvi_pkg::TRS_Z1: begin
          trs_d = (smp == `CVI_TRS_ZERO) ? cvi_pkg::TRS_Z2 : cvi_pkg::TRS_IDLE;
        end
        cvi_pkg::TRS_Z2: begin
          trs_d = cvi_pkg::TRS_IDLE;
          if (hv) begin
            if (act_q) begin
              mw_d = {5'h00, samp_q[11:1]};
              lines_d = lcount;
            end
            act_d = 1'b0;
            samp_d = '0;
            if (vv & ~vprev_q) begin
              // End of field
              lines_d = '0;
              accept_d = 1'b0;
              hold_v_d = 1'b0;
              if (hold_v_q & accept_q) begin
                if (gen_q | ~fin_ready) begin
                  ovf_d = 1'b1;
                end else begin
                  fin_valid = 1'b1;
                  fin_data = '{sop: 1'b0, eop: 1'b1, data: hold_q}; // R01
                end
              end
              // A field whose start was never seen is not measured
              live_d = 1'b0;
              if (live_q & field_q) begin // R03
                if (seen0_q) begin
                  sw_d = mw_d; // R03 R08
                  sh0_d = mh0_q;
                  sh1_d = {5'h00, lcount};
                  si_d = 1'b1;
                  sval_d = 1'b1;
                end
                seen0_d = 1'b0;
              end else if (live_q) begin
                mh0_d = {5'h00, lcount};
                if (seen0_q) begin
                  sw_d = mw_d; // R03 R08
                  sh0_d = {5'h00, lcount};
                  sh1_d = {5'h00, lcount};
                  si_d = 1'b0;
                  sval_d = 1'b1;
                end
                seen0_d = 1'b1;
              end
              chg_d = (sval_d & ~sval_q) | (sw_d != sw_q) | (sh0_d != sh0_q) |
                      (sh1_d != sh1_q) | (si_d != si_q); // R09
            end
            if (~vv & vprev_q) begin
              // Start of field: gate on enable, then send the header
              field_d = fv;
              live_d = 1'b1; // R03
              accept_d = enable_i; // R07
              if (enable_i) begin
                gen_d = 1'b1; // R04 R05
                gen_idx_d = 4'h0;
              end
            end
            vprev_d = vv;
          end else begin
            act_d = ~vv; // R01
          end
        end
        default: trs_d = cvi_pkg::TRS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      trs_q <= cvi_pkg::TRS_IDLE;
      {act_q, vprev_q, field_q, accept_q, seen0_q, gen_q, hold_v_q, live_q} <= '0;
      {gen_idx_q, hold_q, samp_q, lines_q} <= '0;
      {mw_q, mh0_q, sw_q, sh0_q, sh1_q} <= '0;
      {si_q, sval_q, chg_q, ovf_q} <= '0;
    end else begin
      trs_q <= trs_d;
      {act_q, vprev_q, field_q, accept_q} <= {act_d, vprev_d, field_d, accept_d};
      {seen0_q, gen_q, hold_v_q, live_q} <= {seen0_d, gen_d, hold_v_d, live_d};
      {gen_idx_q, hold_q, samp_q, lines_q} <= {gen_idx_d, hold_d, samp_d, lines_d};
      {mw_q, mh0_q, sw_q, sh0_q, sh1_q} <= {mw_d, mh0_d, sw_d, sh0_d, sh1_d};
      {si_q, sval_q, chg_q, ovf_q} <= {si_d, sval_d, chg_d, ovf_d};
    end
  end

  // ----------------------------------------------------------------
  // Output buffer and status
  // ----------------------------------------------------------------
  cvi_fifo #(
    .WIDTH($bits(cvi_pkg::pkt_word_t)),
    .DEPTH(`CVI_FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .in_data_i(fin_data),
    .in_valid_i(fin_valid),
    .in_ready_o(fin_ready),
    .out_data_o(fout_data),
    .out_valid_o(fout_valid),
    .out_ready_i(dout_ready_i)
  );

  assign {dout_sop_o, dout_eop_o, dout_data_o} = fout_data; // R05
  assign dout_valid_o = fout_valid;
  assign {width_o, height0_o, height1_o, interlaced_o} = {sw_q, sh0_q, sh1_q, si_q}; // R08
  assign status_valid_o = sval_q;
  assign status_change_o = chg_q; // R09
  assign overflow_o = ovf_q;

endmodule
`default_nettype wire

//--- core/cvi_defs.svh
// Constants for the clocked video input packetizer
`ifndef CVI_DEFS_SVH
`define CVI_DEFS_SVH

// ----------------------------------------------------------------
// Embedded sync codes
// ----------------------------------------------------------------
`define CVI_TRS_MARK 8'hFF
`define CVI_TRS_ZERO 8'h00
`define CVI_BIT_F 6
`define CVI_BIT_V 5
`define CVI_BIT_H 4

// ----------------------------------------------------------------
// Initial control packet values
// ----------------------------------------------------------------
`define CVI_DEF_WIDTH 16'h02D0
`define CVI_DEF_H0 16'h00F4
`define CVI_DEF_H1 16'h00F3
`define CVI_DEF_INTL 1'b1

// ----------------------------------------------------------------
// Packet layout
// ----------------------------------------------------------------
`define CVI_TYPE_CTRL 4'hF
`define CVI_TYPE_VIDEO 4'h0
`define CVI_GEN_EOP 4'h9
`define CVI_GEN_LAST 4'hA
`define CVI_FIFO_DEPTH 4

`endif

//--- core/cvi_pkg.sv
// Types for the clocked video input packetizer
package cvi_pkg;

  typedef struct packed {
    logic sop;
    logic eop;
    logic [7:0] data;
  } pkt_word_t;

  typedef enum logic [1:0] {
    TRS_IDLE,
    TRS_MARK,
    TRS_Z1,
    TRS_Z2
  } trs_state_t;

endpackage

//--- sim/cvi_top_sva.sv
// Checker for the packetizer stream and status outputs
`timescale 1ns/1ns
`default_nettype none
`include "cvi_defs.svh"
module cvi_top_sva (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Stream out
  input wire logic [7:0] dout_data_o,
  input wire logic dout_sop_o,
  input wire logic dout_eop_o,
  input wire logic dout_valid_o,
  input wire logic dout_ready_i,
  // Status
  input wire logic [15:0] width_o,
  input wire logic [15:0] height0_o,
  input wire logic [15:0] height1_o,
  input wire logic interlaced_o,
  input wire logic status_valid_o,
  input wire logic status_change_o,
  input wire logic overflow_o
);
  default clocking dcb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic in_pkt_q;
  logic in_pkt_d;
  // -------------------------------------------------------------
  // Packet tracking
  // -------------------------------------------------------------
  sequence s_taken;
    dout_valid_o && dout_ready_i;
  endsequence
  sequence s_open;
    s_taken ##0 dout_sop_o;
  endsequence
  always_comb begin
    in_pkt_d = in_pkt_q;
    if (dout_valid_o && dout_ready_i) begin
      in_pkt_d = !dout_eop_o;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      in_pkt_q <= 1'b0;
    end else begin
      in_pkt_q <= in_pkt_d;
    end
  end
  a_sop_opens_pkt: assert property (!in_pkt_q ##0 s_taken |-> dout_sop_o)
    else $error("word outside a packet without start flag");
  a_no_nested_sop: assert property (in_pkt_q ##0 s_taken |-> !dout_sop_o)
    else $error("start flag inside an open packet");
  a_pkt_type_code: assert property (s_open |-> dout_data_o == {4'h0, `CVI_TYPE_CTRL}
    || dout_data_o == {4'h0, `CVI_TYPE_VIDEO}) else $error("bad packet type word");
  a_stall_holds_word: assert property (dout_valid_o && !dout_ready_i |=> dout_valid_o
    && $stable({dout_data_o, dout_sop_o, dout_eop_o})) else $error("word changed in stall");
  a_change_one_cycle: assert property (status_change_o |=> !status_change_o)
    else $error("status change pulse too long");
  a_change_needs_valid: assert property (status_change_o |-> status_valid_o)
    else $error("status change before valid format");
  a_valid_stays_high: assert property (status_valid_o |=> status_valid_o)
    else $error("status valid dropped");
  a_format_announced: assert property ($changed({width_o, height0_o, height1_o,
    interlaced_o}) |-> ##[0:1] status_change_o) else $error("format changed silently");
  a_drop_one_cycle: assert property (overflow_o |=> !overflow_o)
    else $error("overflow pulse too long");
  a_reset_idle: assert property ($rose(rstn_i) |-> !dout_valid_o && !status_valid_o)
    else $error("outputs busy after reset");
endmodule
bind cvi_top cvi_top_sva cvi_top_sva_inst (.core_clk_i, .rstn_i, .dout_data_o, .dout_sop_o,
  .dout_eop_o, .dout_valid_o, .dout_ready_i, .width_o, .height0_o, .height1_o,
  .interlaced_o, .status_valid_o, .status_change_o, .overflow_o);
`default_nettype wire

//--- sim/video_source_model.sv
// Behavioural model of the decoder that sends clocked video
`timescale 1ns/1ns
`default_nettype none
module video_source_model (
  // Clocked video out
  output logic vid_clk_o,
  output logic [7:0] vid_data_o,
  output logic vid_datavalid_o,
  output logic vid_locked_o
);
  // Pixel clock runs free, as a decoder's does; phase unrelated to the core
  initial begin
    vid_clk_o = 1'b0;
    vid_data_o = 8'h10;
    vid_datavalid_o = 1'b1;
    vid_locked_o = 1'b1;
    #3;
    forever #40 vid_clk_o = ~vid_clk_o;
  end
  task automatic put(input logic [7:0] v);
    @(negedge vid_clk_o);
    vid_data_o = v;
  endtask
  task automatic trs(input logic f, input logic v, input logic h);
    put(8'hFF);
    put(8'h00);
    put(8'h00);
    put({1'b1, f, v, h, 4'h0});
  endtask
  task automatic line(input logic f, input logic v, input int n, input int l);
    trs(f, v, 1'b1);
    repeat (2) begin
      put(8'h80);
      put(8'h10);
    end
    trs(f, v, 1'b0);
    for (int i = 0; i < n; i++) begin
      put(v ? 8'h10 : 8'(32'h20 + l * 16 + i));
    end
  endtask
  // Blanking lines, active lines, then one blanking line whose sync ends the field
  task automatic send_field(input logic f, input int lines, input int n);
    repeat (2) line(f, 1'b1, n, 0);
    for (int l = 0; l < lines; l++) begin
      line(f, 1'b0, n, l);
    end
    line(f, 1'b1, n, 0);
  endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the clocked video input packetizer
`timescale 1ns/1ns
`default_nettype none
`include "cvi_defs.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  typedef struct packed {
    logic en;
    logic f;
    logic [3:0] lines;
    logic [3:0] n;
    logic [1:0] mode;
  } row_t;
  // Stall mode 1 lets a word pass every third cycle, mode 2 stops the sink
  row_t rows [7] = '{'{1'b0, 1'b1, 4'd2, 4'd8, 2'd0}, '{1'b1, 1'b0, 4'd3, 4'd8, 2'd0},
    '{1'b1, 1'b1, 4'd2, 4'd8, 2'd0}, '{1'b1, 1'b0, 4'd2, 4'd6, 2'd1},
    '{1'b1, 1'b0, 4'd3, 4'd6, 2'd0}, '{1'b1, 1'b1, 4'd2, 4'd6, 2'd0},
    '{1'b1, 1'b0, 4'd2, 4'd6, 2'd2}};
  logic core_clk_i, rstn_i, enable_i, rdy, m_valid, m_intl, pf, xc;
  logic dout_ready_i = 1'b1;
  logic [1:0] mode = 2'd0;
  wire logic vid_clk_i, vid_datavalid_i, vid_locked_i;
  wire logic [7:0] vid_data_i;
  logic [7:0] dout_data_o;
  logic dout_sop_o, dout_eop_o, dout_valid_o, interlaced_o;
  logic status_valid_o, status_change_o, overflow_o;
  logic [15:0] width_o, height0_o, height1_o, m_w, m_h0, m_h1;
  int n_mismatch = 0, tests_run = 0, cyc = 0, n_chg = 0, n_ovf = 0, plines = 0;
  cvi_pkg::pkt_word_t got_q[$], exp_q[$];
  video_source_model video_source_model_inst (.vid_clk_o(vid_clk_i), .vid_data_o(vid_data_i),
    .vid_datavalid_o(vid_datavalid_i), .vid_locked_o(vid_locked_i));
  cvi_top cvi_top_inst (.core_clk_i, .rstn_i, .vid_clk_i, .vid_data_i, .vid_datavalid_i,
    .vid_locked_i, .enable_i, .dout_data_o, .dout_sop_o, .dout_eop_o, .dout_valid_o,
    .dout_ready_i, .width_o, .height0_o, .height1_o, .interlaced_o, .status_valid_o,
    .status_change_o, .overflow_o);
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // -------------------------------------------------------------
  // Sink, monitor and timeout
  // -------------------------------------------------------------
  // One process sets ready and logs the word that the next edge takes
  always @(negedge core_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  always @(negedge core_clk_i) begin
    rdy = (mode == 2'd0) || (mode == 2'd1 && cyc % 3 == 0);
    if (dout_valid_o === 1'b1 && rdy) got_q.push_back({dout_sop_o, dout_eop_o, dout_data_o});
    if (status_change_o === 1'b1) n_chg++;
    if (overflow_o === 1'b1) n_ovf++;
    dout_ready_i = rdy;
  end
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic run_row(input row_t r);
    logic [15:0] w;
    logic [15:0] h;
    logic [48:0] nf;
    int c0;
    int o0;
    @(negedge core_clk_i);
    enable_i <= r.en;
    mode <= r.mode;
    c0 = n_chg;
    o0 = n_ovf;
    got_q.delete();
    exp_q.delete();
    w = m_valid ? m_w : `CVI_DEF_WIDTH;
    h = m_valid ? ((m_intl && r.f) ? m_h1 : m_h0) : (r.f ? `CVI_DEF_H1 : `CVI_DEF_H0);
    if (r.en) begin
      exp_q.push_back({2'b10, 4'h0, `CVI_TYPE_CTRL});
      for (int s = 12; s >= 0; s -= 4) exp_q.push_back({6'h00, w[s+:4]});
      for (int s = 12; s >= 0; s -= 4) exp_q.push_back({6'h00, h[s+:4]});
      exp_q.push_back({2'b01, 4'h0, m_valid ? m_intl : `CVI_DEF_INTL, r.f, 2'b00});
      exp_q.push_back({2'b10, 4'h0, `CVI_TYPE_VIDEO});
      for (int l = 0; l < r.lines; l++) begin
        for (int s = 0; s < r.n; s++) begin
          exp_q.push_back({1'b0, l == r.lines - 1 && s == r.n - 1, 8'(32'h20 + l * 16 + s)});
        end
      end
    end
    video_source_model_inst.send_field(r.f, r.lines, r.n);
    for (int t = 0; t < 300 && got_q.size() < exp_q.size(); t++) @(negedge core_clk_i);
    if (r.mode == 2'd2) begin
      `CHK(n_ovf > o0, 1'b1)
    end else begin
      `CHK(got_q.size(), exp_q.size())
      foreach (exp_q[k]) `CHK(got_q[k], exp_q[k])
    end
    nf = {16'(r.n / 2), r.f ? 16'(plines) : 16'(r.lines), 16'(r.lines), r.f};
    xc = !pf && (!m_valid || nf != {m_w, m_h0, m_h1, m_intl});
    if (!pf) begin
      m_valid = 1'b1;
      {m_w, m_h0, m_h1, m_intl} = nf;
    end
    pf = r.f;
    plines = r.lines;
    `CHK({width_o, height0_o, height1_o, interlaced_o, status_valid_o},
      {m_w, m_h0, m_h1, m_intl, m_valid})
    `CHK(n_chg - c0, xc ? 1 : 0)
  endtask
  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    rstn_i = 1'b0;
    enable_i = 1'b0;
    {m_valid, m_intl, pf, m_w, m_h0, m_h1} = {3'b001, 48'h0};
    repeat (8) @(negedge core_clk_i);
    rstn_i <= 1'b1;
    foreach (rows[k]) run_row(rows[k]);
    @(negedge core_clk_i);
    rstn_i <= 1'b0;
    mode <= 2'd0;
    repeat (8) @(negedge core_clk_i);
    `CHK({dout_valid_o, status_valid_o, status_change_o, overflow_o, width_o}, 20'h0)
    rstn_i <= 1'b1;
    repeat (2) @(negedge core_clk_i);
    report_and_stop();
  end
endmodule
`default_nettype wire
